// file: hdl/imusr_pkg.sv
// Summary of operation
// - interrupt status bit5 shows data ready
// - bit4: gyro fifo count above watermark
// - bit3: accel fifo count above watermark
// - bit2: free-fall event latched
// - bit1: activity event latched
// - bit0: inactivity event latched
// - motion status bit7: sign of last activity or inactivity event
// - motion bits 6:4 flag x,y,z axes
// - accel queue status bit7: fifo full
// - accel queue status bit6: fifo empty
// - accel queue low bits: sample count
// - gyro queue status bit7: fifo full
// - gyro queue status bit6: fifo empty
// - gyro queue low bits: sample count
// - fixed read-only part identifier register
// - converter reset bit4, reset 0, 1 holds
// - clock bit0: 0 pll, 1 oscillator
// - interrupt status read-only, bits 7:6 zero
// - auto-clear interrupt once held ticks exceed count limit
package imusr_pkg;

	localparam logic [7:0] ADDR_INT_STATUS    = 8'h2C;
	localparam logic [7:0] ADDR_MOTION_STATUS = 8'h2D;
	localparam logic [7:0] ADDR_ACCEL_QSTAT   = 8'h2E;
	localparam logic [7:0] ADDR_GYRO_QSTAT    = 8'h2F;
	localparam logic [7:0] ADDR_PART_ID       = 8'h30;
	localparam logic [7:0] ADDR_CLOCK_SRC     = 8'hBA;
	localparam logic [7:0] ADDR_CONV_RESET    = 8'hCA;

	localparam int BIT_DATA_READY  = 5;
	localparam int BIT_GYRO_WMARK  = 4;
	localparam int BIT_ACCEL_WMARK = 3;
	localparam int BIT_FREE_FALL   = 2;
	localparam int BIT_ACTIVITY    = 1;
	localparam int BIT_INACTIVITY  = 0;
	localparam int BIT_SIGN        = 7;
	localparam int BIT_AXIS_X      = 6;
	localparam int BIT_AXIS_Y      = 5;
	localparam int BIT_AXIS_Z      = 4;
	localparam int BIT_Q_FULL      = 7;
	localparam int BIT_Q_EMPTY     = 6;
	localparam int BIT_CONV_RESET  = 4;
	localparam int BIT_CLK_SEL     = 0;

	localparam int          CNT_W         = 6;
	localparam logic [7:0]  RESET_BYTE    = 8'h00;
	localparam logic [7:0]  PART_ID_VALUE = 8'hA5;  // arbitrary value
	localparam int          CLK_HZ        = 50000000;
	localparam int          TICK_HZ       = 250;
	localparam int          TICK_CYCLES   = CLK_HZ / TICK_HZ;

	typedef struct packed {
		logic data_ready;
		logic free_fall_evt;
		logic activity_evt;
		logic inactivity_evt;
		logic evt_sign;
		logic evt_axis_x;
		logic evt_axis_y;
		logic evt_axis_z;
	} imusr_evt_t;

	typedef struct packed {
		logic             fifo_mode;
		logic [CNT_W-1:0] watermark;
		logic [CNT_W-1:0] accel_count;
		logic [CNT_W-1:0] gyro_count;
	} imusr_fifo_t;

	typedef struct packed {
		logic       rd_en;
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} imusr_req_t;

endpackage : imusr_pkg

// file: hdl/imusr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module imusr_regs #(
	parameter int              FIFO_DEPTH  = 32,
	parameter int              TICK_CYCLES = imusr_pkg::TICK_CYCLES,
	parameter logic [7:0]      PART_ID     = imusr_pkg::PART_ID_VALUE
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire imusr_pkg::imusr_req_t  req,
	input  wire imusr_pkg::imusr_evt_t  evt,
	input  wire imusr_pkg::imusr_fifo_t fifo,
	input  wire logic                   auto_clear_en,
	input  wire logic [7:0]             int_count_limit,
	input  wire logic                   event_clear,
	output logic [7:0]                  reg_rdata,
	output logic                        reg_rd_valid,
	output logic                        adc_reset,
	output logic                        sysclk_source_select,
	output logic                        int_out
);
	import imusr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]  rdata;
		logic        rd_valid;
		logic        conv_reset;
		logic        clk_sel;
		logic        ff;
		logic        act;
		logic        inact;
		logic        sign;
		logic [2:0]  axes;
		logic [17:0] tick_cnt;
		logic [7:0]  hold_cnt;
		logic        irq;
	} imusr_state_t;

	imusr_state_t st_r;
	imusr_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// strictly greater, equal to watermark does not count
	function automatic logic over_mark(input logic [CNT_W-1:0] cnt,
		input imusr_fifo_t f);
		over_mark = f.fifo_mode && (cnt > f.watermark);
	endfunction : over_mark

	function automatic logic [7:0] queue_byte(input logic [CNT_W-1:0] cnt);
		logic [7:0] b;
		b = RESET_BYTE;
		b[BIT_Q_FULL]  = (32'(cnt) >= FIFO_DEPTH);
		b[BIT_Q_EMPTY] = (cnt == '0);
		b[CNT_W-1:0]   = cnt;
		queue_byte = b;
	endfunction : queue_byte

	////////////////////////////////////////////////////////////////////////
	logic [7:0] int_byte;
	logic [7:0] motion_byte;
	logic       tick;
	logic       any_evt;

	always_comb begin
		int_byte = RESET_BYTE;
		int_byte[BIT_DATA_READY]  = evt.data_ready;
		int_byte[BIT_GYRO_WMARK]  = over_mark(fifo.gyro_count, fifo);
		int_byte[BIT_ACCEL_WMARK] = over_mark(fifo.accel_count, fifo);
		int_byte[BIT_FREE_FALL]   = st_r.ff;
		int_byte[BIT_ACTIVITY]    = st_r.act;
		int_byte[BIT_INACTIVITY]  = st_r.inact;
		motion_byte = RESET_BYTE;
		motion_byte[BIT_SIGN]   = st_r.sign;
		motion_byte[BIT_AXIS_X] = st_r.axes[2];
		motion_byte[BIT_AXIS_Y] = st_r.axes[1];
		motion_byte[BIT_AXIS_Z] = st_r.axes[0];
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		tick    = (32'(st_r.tick_cnt) >= TICK_CYCLES - 1);
		any_evt = evt.free_fall_evt | evt.activity_evt | evt.inactivity_evt;

		// free-running 250 hz timebase
		st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 18'h00001;

		// latched events; reads never clear them, only the clear paths do
		if (event_clear) begin
			st_nxt.ff    = 1'b0;
			st_nxt.act   = 1'b0;
			st_nxt.inact = 1'b0;
		end
		// interrupt width measured in timebase ticks
		if (!st_r.irq) begin
			st_nxt.hold_cnt = '0;
		end else if (tick && st_r.hold_cnt != 8'hFF) begin
			st_nxt.hold_cnt = st_r.hold_cnt + 8'h01;
		end
		if (auto_clear_en && st_r.irq && st_r.hold_cnt > int_count_limit) begin
			st_nxt.ff       = 1'b0;
			st_nxt.act      = 1'b0;
			st_nxt.inact    = 1'b0;
			st_nxt.hold_cnt = '0;
		end
		// set after clear so a same-cycle event is never lost
		if (evt.free_fall_evt)
			st_nxt.ff = 1'b1;
		if (evt.activity_evt)
			st_nxt.act = 1'b1;
		if (evt.inactivity_evt)
			st_nxt.inact = 1'b1;
		if (evt.activity_evt || evt.inactivity_evt) begin
			st_nxt.sign = evt.evt_sign;
			st_nxt.axes = {evt.evt_axis_x, evt.evt_axis_y, evt.evt_axis_z};
		end
		st_nxt.irq = st_nxt.ff | st_nxt.act | st_nxt.inact;
		if (any_evt && !st_r.irq)
			st_nxt.hold_cnt = '0;

		// register writes, reserved bits stay zero
		if (req.wr_en) begin
			case (req.addr)
				ADDR_CONV_RESET: st_nxt.conv_reset = req.wdata[BIT_CONV_RESET];
				ADDR_CLOCK_SRC:  st_nxt.clk_sel    = req.wdata[BIT_CLK_SEL];
				default:         st_nxt.clk_sel    = st_r.clk_sel;
			endcase
		end

		// register reads, one cycle latency, no side effects
		st_nxt.rd_valid = req.rd_en;
		if (req.rd_en) begin
			case (req.addr)
				ADDR_INT_STATUS:    st_nxt.rdata = int_byte;
				ADDR_MOTION_STATUS: st_nxt.rdata = motion_byte;
				ADDR_ACCEL_QSTAT:   st_nxt.rdata = queue_byte(fifo.accel_count);
				ADDR_GYRO_QSTAT:    st_nxt.rdata = queue_byte(fifo.gyro_count);
				ADDR_PART_ID:       st_nxt.rdata = PART_ID;
				ADDR_CLOCK_SRC:     st_nxt.rdata = {7'h00, st_r.clk_sel};
				ADDR_CONV_RESET:    st_nxt.rdata = {3'h0, st_r.conv_reset, 4'h0};
				default:            st_nxt.rdata = RESET_BYTE;
			endcase
		end
	end
	// queue_byte also carries empty and count fields

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata            = st_r.rdata;
	assign reg_rd_valid         = st_r.rd_valid;
	assign adc_reset            = st_r.conv_reset;
	assign sysclk_source_select = st_r.clk_sel;
	assign int_out              = st_r.irq;

endmodule : imusr_regs
`default_nettype wire

// file: tb/imusr_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module imusr_regs_asserts #(
	parameter int         FIFO_DEPTH  = 32,
	parameter int         TICK_CYCLES = 10,
	parameter logic [7:0] PART_ID     = 8'hA5
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire imusr_pkg::imusr_req_t  req,
	input wire imusr_pkg::imusr_evt_t  evt,
	input wire imusr_pkg::imusr_fifo_t fifo,
	input wire logic                   auto_clear_en,
	input wire logic [7:0]             int_count_limit,
	input wire logic                   event_clear,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   reg_rd_valid,
	input wire logic                   adc_reset,
	input wire logic                   sysclk_source_select,
	input wire logic                   int_out
);
	import imusr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sequence s_rd(logic [7:0] a);
		req.rd_en && req.addr == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		req.wr_en && req.addr == a;
	endsequence
	property p_rdv;
		req.rd_en |=> reg_rd_valid;
	endproperty
	a_rdv: assert property (p_rdv) else $error("read not answered");
	property p_id;
		s_rd(ADDR_PART_ID) |=> reg_rdata == PART_ID;
	endproperty
	a_id: assert property (p_id) else $error("bad part code");
	// watermark compare is strict and gated by mode
	property p_is;
		logic [2:0] v;
		(s_rd(ADDR_INT_STATUS), v = {evt.data_ready,
			fifo.fifo_mode && fifo.gyro_count > fifo.watermark,
			fifo.fifo_mode && fifo.accel_count > fifo.watermark}) |=> reg_rdata[7:3] == {2'b00, v};
	endproperty
	a_is: assert property (p_is) else $error("bad int status");
	property p_aq;
		logic [5:0] c;
		(s_rd(ADDR_ACCEL_QSTAT), c = fifo.accel_count) |=> reg_rdata == {c >= FIFO_DEPTH, c == 0, c};
	endproperty
	a_aq: assert property (p_aq) else $error("bad accel queue");
	property p_gq;
		logic [5:0] c;
		(s_rd(ADDR_GYRO_QSTAT), c = fifo.gyro_count) |=> reg_rdata == {c >= FIFO_DEPTH, c == 0, c};
	endproperty
	a_gq: assert property (p_gq) else $error("bad gyro queue");
	property p_ev;
		evt.free_fall_evt || evt.activity_evt || evt.inactivity_evt |=> int_out;
	endproperty
	a_ev: assert property (p_ev) else $error("event lost");
	property p_ck;
		logic [7:0] d;
		(s_wr(ADDR_CLOCK_SRC), d = req.wdata) |=> sysclk_source_select == d[0];
	endproperty
	a_ck: assert property (p_ck) else $error("clock select not written");
	property p_ad;
		logic [7:0] d;
		(s_wr(ADDR_CONV_RESET), d = req.wdata) |=> adc_reset == d[4];
	endproperty
	a_ad: assert property (p_ad) else $error("converter reset not written");
endmodule : imusr_regs_asserts
bind imusr_regs imusr_regs_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .TICK_CYCLES(TICK_CYCLES),
	.PART_ID(PART_ID)) u_chk (.clk, .rst, .req, .evt, .fifo, .auto_clear_en, .int_count_limit,
	.event_clear, .reg_rdata, .reg_rd_valid, .adc_reset, .sysclk_source_select, .int_out);
`default_nettype wire

// file: tb/imusr_host.sv
`timescale 1ns/10ps
`default_nettype none
module imusr_host (
	input wire logic                  clk,
	output var imusr_pkg::imusr_req_t req,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  reg_rd_valid
);
	import imusr_pkg::*;
	initial req = '0;
	////////////////////////////////////////////////////////////////
	// idle lines show the inverse so stale values never pass
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
		@(negedge clk);
		repeat (3) if (reg_rd_valid !== 1'b1) @(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk) req <= '{1'b0, 1'b1, a, w};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, ~w};
	endtask : wr
endmodule : imusr_host
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import imusr_pkg::*;
	logic clk = 0, rst = 1, ace = 0, ecl = 0, rdv, adc, sel, io;
	logic [7:0] lim = 0, d, rd;
	imusr_req_t req;
	imusr_evt_t evt = '0;
	imusr_fifo_t ff = '0;
	int err_count = 0, comparisons = 0;
	logic [7:0] ra[6] = '{8'h2C, 8'h2D, 8'h30, 8'hBA, 8'hCA, 8'h31};
	logic [7:0] re[6] = '{8'h00, 8'h00, PART_ID_VALUE, 8'h00, 8'h00, 8'h00};
	always #10 clk = ~clk;
	// short tick keeps auto clear within a few dozen cycles
	imusr_regs #(.TICK_CYCLES(10)) DUT (.clk, .rst, .req, .evt, .fifo(ff), .auto_clear_en(ace),
		.int_count_limit(lim), .event_clear(ecl), .reg_rdata(rd), .reg_rd_valid(rdv),
		.adc_reset(adc), .sysclk_source_select(sel), .int_out(io));
	imusr_host H (.clk, .req, .reg_rdata(rd), .reg_rd_valid(rdv));
	////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task rc(input logic [7:0] a, input logic [7:0] e);
		H.rd(a, d);
		chk({7'h0, rdv}, 8'h01);
		chk(d, e);
	endtask : rc
	task summarize;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		#100000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 6; i++) rc(ra[i], re[i]);
		H.wr(8'hBA, 8'hFF);
		rc(8'hBA, 8'h01);
		chk({7'h0, sel}, 8'h01);
		H.wr(8'hCA, 8'hFF);
		rc(8'hCA, 8'h10);
		chk({7'h0, adc}, 8'h01);
		H.wr(8'h30, 8'h00);
		rc(8'h30, PART_ID_VALUE);
		@(posedge clk) ff <= '{1'b1, 6'h05, 6'h05, 6'h06};
		evt.data_ready <= 1;
		rc(8'h2C, 8'h30);
		@(posedge clk) ff <= '{1'b0, 6'h05, 6'h06, 6'h06};
		rc(8'h2C, 8'h20);
		@(posedge clk) ff <= '{1'b1, 6'h05, 6'h20, 6'h00};
		rc(8'h2E, 8'hA0);
		rc(8'h2F, 8'h40);
		rc(8'h2C, 8'h28);
		@(posedge clk) evt <= 8'hAD;
		@(posedge clk) evt <= 8'h80;
		rc(8'h2D, 8'hD0);
		rc(8'h2C, 8'h2A);
		rc(8'h2C, 8'h2A);
		chk({7'h0, io}, 8'h01);
		@(posedge clk) ecl <= 1;
		@(posedge clk) ecl <= 0;
		rc(8'h2C, 8'h28);
		@(posedge clk) evt <= 8'hD0;
		@(posedge clk) evt <= 8'h80;
		rc(8'h2C, 8'h2D);
		rc(8'h2D, 8'h00);
		@(posedge clk) ecl <= 1;
		@(posedge clk) ecl <= 0;
		ace <= 1;
		lim <= 8'h02;
		evt <= 8'hC0;
		@(posedge clk) evt <= 8'h80;
		@(negedge clk) chk({7'h0, io}, 8'h01);
		repeat (60) @(posedge clk);
		@(negedge clk) chk({7'h0, io}, 8'h00);
		summarize();
	end
endmodule : tb
`default_nettype wire
